// [logic/stc_pkg.sv]
/*
  Package for the 16-bit timer/counter: register map, control field layout,
  reset values and prescale codes.
  Assumes an Avalon-MM slave with 32-bit data and byte addresses.
*/
`default_nettype none
package stc_pkg;
  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] STC_OFS_CONTROL = 8'h10;
  localparam logic [7:0] STC_OFS_COUNT_LOW = 8'h14;
  localparam logic [7:0] STC_OFS_COUNT_HIGH = 8'h18;
  localparam logic [7:0] STC_OFS_IRQ = 8'h1c;
  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int STC_BIT_RUN = 0;
  localparam int STC_BIT_SRC = 1;
  localparam int STC_BIT_SYNC_N = 2;
  localparam int STC_BIT_OSC_EN = 3;
  localparam int STC_BIT_PS_LO = 4;
  localparam int STC_BIT_PS_HI = 5;
  localparam logic [5:0] STC_CONTROL_MASK = 6'h3f;
  localparam logic [5:0] STC_CONTROL_RESET = 6'h00;
  // Interrupt word: bit 0 flag (write 1 clears), bit 1 enable
  localparam int STC_BIT_IRQ_FLAG = 0;
  localparam int STC_BIT_IRQ_EN = 1;
  // ****************************************************************
  // Counter constants
  // ****************************************************************
  localparam logic [15:0] STC_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] STC_COUNT_MAX = 16'hffff;
  localparam logic [2:0] STC_PS_ZERO = 3'h0;
  localparam logic [1:0] STC_PS_DIV1 = 2'h0;
  localparam logic [1:0] STC_PS_DIV2 = 2'h1;
  localparam logic [1:0] STC_PS_DIV4 = 2'h2;
  localparam logic [1:0] STC_PS_DIV8 = 2'h3;
  typedef enum logic [1:0] {
    STC_BUS_IDLE = 2'b01,
    STC_BUS_ACK = 2'b10
  } stc_bus_e;
endpackage : stc_pkg
`default_nettype wire

// [logic/stc_edge_if.sv]
/*
  Interface between the timer top and its edge qualifier.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface stc_edge_if;
  logic pin;
  logic arm;
  logic rise;
  modport qual (input pin, input arm, output rise);
  modport user (output pin, output arm, input rise);
endinterface : stc_edge_if
`default_nettype wire

// [logic/stc_edge_qual.sv]
/*
  Edge qualifier: reports rising edges of the selected count pin, but only
  after a falling edge has been seen since it was armed.
  Assumes the pin is already synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module stc_edge_qual
  import stc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Edge link
  stc_edge_if.qual eif
);
  typedef struct packed {
    logic prev;
    logic seen_fall;
  } stc_eq_s;
  stc_eq_s st_ff;
  stc_eq_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.prev = eif.pin;
    if (!eif.arm)
    begin
      nxt_st.seen_fall = 1'b0;
    end
    else if (st_ff.prev && !eif.pin)
    begin
      nxt_st.seen_fall = 1'b1;
    end
  end

  // First counted rise is the one after the first fall
  assign eif.rise = eif.arm && st_ff.seen_fall && !st_ff.prev && eif.pin;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : stc_edge_qual
`default_nettype wire

// [logic/stc_timer.sv]
/*
  16-bit timer/counter with 3-bit prescaler, overflow flag and mask,
  compare-unit clear and crystal pin control, on an Avalon-MM slave.
  Assumes external pins are synchronous to clk_sys_i and that the
  instruction-cycle tick is a one-cycle pulse from the core.
*/
// Notes on behaviour
// - Counter counts up, wraps ffff to 0000, and each wrap sets overflow flag.
// - Interrupt request is overflow flag gated by its enable bit.
// - Control bit 1 picks external counter (1) or internal timer (0).
// - Timer mode advances once per instruction cycle after prescale.
// - Counting only while run enable bit 0 is set; otherwise hold.
// - Prescale bits 5:4 select divide by 1, 2, 4 or 8.
// - Crystal enable forces both oscillator pins to inputs, ignoring direction bits.
// - Sync control bit 2 is ignored in timer mode.
// - Counter mode takes edges from oscillator input if crystal enabled, else clock pin.
// - Sync active-low: sync happens after prescaler; prescaler is a plain counter.
// - Synchronized counter mode in sleep: counter stops, prescaler keeps counting.
// - Unsynchronized mode counts in sleep; overflow sets flag and, with irq enable set, wakes core.
// - No valid time base for compare units in unsynchronized mode.
// - Reading either byte half always returns a coherent value.
// - Compare-unit reset input clears the counter.
// - A software counter write beats a simultaneous compare clear.
`timescale 1ns/1ps
`default_nettype none
module stc_timer
  import stc_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Core side
  input wire logic instr_tick_i,
  input wire logic sleep_i,
  input wire logic compare_clear_i,
  input wire logic [1:0] port_direction_bits_i,
  // Pins
  input wire logic ext_count_pin_i,
  input wire logic osc_input_pin_i,
  output logic [1:0] osc_pin_input_only_o,
  // Events
  output logic overflow_irq_o,
  output logic wake_o,
  output logic time_base_valid_o,
  output logic [COUNT_W-1:0] count_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    stc_bus_e bus;
    logic [31:0] rdata;
    logic [5:0] control;
    logic flag;
    logic irq_en;
    logic [COUNT_W-1:0] count;
    logic [2:0] ps;
  } stc_top_s;
  stc_top_s st_ff;
  stc_top_s nxt_st;

  stc_edge_if eif ();

  logic run;
  logic ext_mode;
  logic sync_n;
  logic osc_en;
  logic [1:0] ps_sel;
  logic src_edge;
  logic [2:0] ps_inc;
  logic ps_out;
  logic tick;
  logic wr_low;
  logic wr_high;
  logic wr_ctl;
  logic wr_irq;
  logic wrap;
  logic [31:0] rd_mux;

  assign run = st_ff.control[STC_BIT_RUN];
  assign ext_mode = st_ff.control[STC_BIT_SRC];
  assign sync_n = st_ff.control[STC_BIT_SYNC_N];
  assign osc_en = st_ff.control[STC_BIT_OSC_EN];
  assign ps_sel = st_ff.control[STC_BIT_PS_HI:STC_BIT_PS_LO];

  // ****************************************************************
  // Input edge selection
  // ****************************************************************
  assign eif.pin = osc_en ? osc_input_pin_i : ext_count_pin_i;
  assign eif.arm = ext_mode;

  stc_edge_qual u_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .eif (eif)
  );

  // Timer mode uses the instruction tick and never looks at sync
  assign src_edge = run && (ext_mode ? eif.rise : instr_tick_i);

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  assign ps_inc = st_ff.ps + 3'h1;

  always_comb
  begin
    unique case (ps_sel)
      STC_PS_DIV1: ps_out = src_edge;
      STC_PS_DIV2: ps_out = src_edge && st_ff.ps[0];
      STC_PS_DIV4: ps_out = src_edge && (st_ff.ps[1:0] == 2'h3);
      STC_PS_DIV8: ps_out = src_edge && (st_ff.ps == 3'h7);
    endcase
  end

  // Synchronized external counting stalls in sleep; prescaler runs on
  // Unsynchronized mode keeps counting through sleep
  assign tick = ps_out && !(ext_mode && !sync_n && sleep_i);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign wr_ctl = avs_write_i && st_ff.bus == STC_BUS_IDLE
    && avs_address_i == STC_OFS_CONTROL && avs_byteenable_i[0];
  assign wr_low = avs_write_i && st_ff.bus == STC_BUS_IDLE
    && avs_address_i == STC_OFS_COUNT_LOW && avs_byteenable_i[0];
  assign wr_high = avs_write_i && st_ff.bus == STC_BUS_IDLE
    && avs_address_i == STC_OFS_COUNT_HIGH && avs_byteenable_i[0];
  assign wr_irq = avs_write_i && st_ff.bus == STC_BUS_IDLE
    && avs_address_i == STC_OFS_IRQ && avs_byteenable_i[0];
  assign wrap = tick && st_ff.count == STC_COUNT_MAX;

  // Count lives in the system domain, so byte reads are always coherent
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (avs_address_i)
      STC_OFS_CONTROL: rd_mux = {26'h0, st_ff.control};
      STC_OFS_COUNT_LOW: rd_mux = {24'h0, st_ff.count[7:0]};
      STC_OFS_COUNT_HIGH: rd_mux = {24'h0, st_ff.count[15:8]};
      STC_OFS_IRQ: rd_mux = {30'h0, st_ff.irq_en, st_ff.flag};
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    // One wait cycle per access; data registered for the ack cycle
    unique case (st_ff.bus)
      STC_BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          nxt_st.bus = STC_BUS_ACK;
          nxt_st.rdata = avs_read_i ? rd_mux : st_ff.rdata;
        end
      end
      STC_BUS_ACK:
      begin
        nxt_st.bus = STC_BUS_IDLE;
      end
      default:
      begin
        nxt_st.bus = STC_BUS_IDLE;
      end
    endcase
    if (wr_ctl)
    begin
      nxt_st.control = avs_writedata_i[5:0] & STC_CONTROL_MASK;
    end
    if (wr_irq)
    begin
      nxt_st.irq_en = avs_writedata_i[STC_BIT_IRQ_EN];
      if (avs_writedata_i[STC_BIT_IRQ_FLAG])
      begin
        nxt_st.flag = 1'b0;
      end
    end
    if (wrap)
    begin
      nxt_st.flag = 1'b1;
    end
    if (src_edge)
    begin
      nxt_st.ps = ps_inc;
    end
    if (tick)
    begin
      nxt_st.count = st_ff.count + 16'h1;
    end
    // A counter write in the same cycle cancels the clear entirely
    if (compare_clear_i && !(wr_low || wr_high))
    begin
      nxt_st.count = STC_COUNT_ZERO;
    end
    // Software write comes last so it beats a concurrent increment
    if (wr_low)
    begin
      nxt_st.count[7:0] = avs_writedata_i[7:0];
    end
    if (wr_high)
    begin
      nxt_st.count[15:8] = avs_writedata_i[7:0];
    end
    if (wr_low || wr_high)
    begin
      nxt_st.ps = STC_PS_ZERO;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff.bus <= STC_BUS_IDLE;
      st_ff.rdata <= 32'h0;
      st_ff.control <= STC_CONTROL_RESET;
      st_ff.flag <= 1'b0;
      st_ff.irq_en <= 1'b0;
      st_ff.count <= STC_COUNT_ZERO;
      st_ff.ps <= STC_PS_ZERO;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && st_ff.bus != STC_BUS_ACK;
  assign avs_readdata_o = st_ff.rdata;
  assign overflow_irq_o = st_ff.flag && st_ff.irq_en;
  // Only the unsynchronized path may wake a sleeping core
  assign wake_o = overflow_irq_o && sleep_i && ext_mode && sync_n;
  // Compare units must not trust the count in unsynchronized mode
  assign time_base_valid_o = !(ext_mode && sync_n);
  // Crystal enable makes both pins inputs whatever the direction bits say
  assign osc_pin_input_only_o = osc_en ? 2'h3 : port_direction_bits_i;
  assign count_o = st_ff.count;
endmodule : stc_timer
`default_nettype wire

// [tb/stc_timer_checker.sv]
/* Checker on the timer top ports.
   Bound to every stc_timer instance; single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module stc_timer_checker
  import stc_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Core and pins
  input wire logic instr_tick_i,
  input wire logic sleep_i,
  input wire logic compare_clear_i,
  input wire logic [1:0] port_direction_bits_i,
  input wire logic ext_count_pin_i,
  input wire logic osc_input_pin_i,
  // Events
  input wire logic [1:0] osc_pin_input_only_o,
  input wire logic overflow_irq_o,
  input wire logic wake_o,
  input wire logic [COUNT_W-1:0] count_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ****************
  // Count sources, pins, wake, irq and bus
  // ****************
  // Two quiet cycles, since a pin rise lands one edge after it is seen
  sequence quiet_s;
    !instr_tick_i && !compare_clear_i && !avs_write_i
      && $stable(ext_count_pin_i) && $stable(osc_input_pin_i);
  endsequence
  sequence low_take_s;
    avs_write_i && avs_waitrequest_o && avs_byteenable_i[0]
      && avs_address_i == STC_OFS_COUNT_LOW;
  endsequence
  count_hold_a: assert property (
    quiet_s [*2] |=> $stable(count_o)) else $error("count moved without a source");
  count_step_a: assert property (
    !compare_clear_i && !avs_write_i
      |=> count_o == $past(count_o) || count_o == $past(count_o) + 1'b1)
    else $error("count moved by more than one");
  clear_count_a: assert property (
    compare_clear_i && !avs_write_i |=> count_o == STC_COUNT_ZERO)
    else $error("compare clear ignored");
  write_wins_a: assert property (
    low_take_s ##0 compare_clear_i |=> count_o[7:0] == $past(avs_writedata_i[7:0])
      && count_o[15:8] == $past(count_o[15:8]))
    else $error("clear beat the count write");
  osc_dir_a: assert property (
    osc_pin_input_only_o == 2'h3 || osc_pin_input_only_o == port_direction_bits_i)
    else $error("oscillator pin direction wrong");
  wake_gate_a: assert property (
    wake_o |-> sleep_i && overflow_irq_o) else $error("wake without sleep and irq");
  irq_hold_a: assert property (
    overflow_irq_o && !avs_write_i |=> overflow_irq_o) else $error("irq dropped alone");
  read_wait_a: assert property (
    avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("read not answered");
endmodule : stc_timer_checker
bind stc_timer stc_timer_checker #(.COUNT_W(COUNT_W)) u_chk (
  .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_waitrequest_o, .instr_tick_i, .sleep_i, .compare_clear_i,
  .port_direction_bits_i, .ext_count_pin_i, .osc_input_pin_i, .osc_pin_input_only_o,
  .overflow_irq_o, .wake_o, .count_o
);
`default_nettype wire

// [tb/stc_clk_source.sv]
/* External count source: clock pin or crystal making pulse bursts.
   Assumes go_i is a one-cycle pulse on clk_sys_i. */
`timescale 1ns/1ps
`default_nettype none
module stc_clk_source (
  // Clock
  input wire logic clk_sys_i,
  // Control
  input wire logic go_i,
  input wire logic [7:0] pulses_i,
  input wire logic use_osc_i,
  input wire logic slow_i,
  // Pins
  output logic ext_count_pin_o,
  output logic osc_input_pin_o,
  output logic busy_o
);
  logic [7:0] left_ff = 8'h00;
  logic [2:0] ph_ff = 3'h0;
  logic noise_ff = 1'b0;
  logic lvl;
  logic nz;
  // Idle high, so every pulse is a fall and then a counted rise
  assign busy_o = left_ff != 8'h00;
  assign lvl = !busy_o || (slow_i ? ph_ff[2] : ph_ff[1]);
  // The other pin toggles during a burst and must not count
  assign nz = !busy_o || noise_ff;
  assign ext_count_pin_o = use_osc_i ? nz : lvl;
  assign osc_input_pin_o = use_osc_i ? lvl : nz;
  always_ff @(posedge clk_sys_i)
  begin
    noise_ff <= ~noise_ff;
    if (go_i)
    begin
      left_ff <= pulses_i;
      ph_ff <= 3'h0;
    end
    else if (busy_o)
    begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == (slow_i ? 3'h7 : 3'h3))
      begin
        ph_ff <= 3'h0;
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule : stc_clk_source
`default_nettype wire

// [tb/stc_timer_tb.sv]
/* Testbench: register tests over the bus and bursts from the source.
   Assumes the 40 MHz system clock and stc_pkg offsets. */
`timescale 1ns/1ps
`default_nettype none
module stc_timer_tb
  import stc_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic instr_tick_i = 1'b0;
  logic sleep_i = 1'b0;
  logic clr_lvl = 1'b0;
  logic clr_wr = 1'b0;
  logic compare_clear_i;
  logic [1:0] port_direction_bits_i = 2'h1;
  logic ext_count_pin_i;
  logic osc_input_pin_i;
  logic [1:0] osc_pin_input_only_o;
  logic overflow_irq_o;
  logic wake_o;
  logic time_base_valid_o;
  logic [15:0] count_o;
  logic go = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic use_osc = 1'b0;
  logic slow = 1'b0;
  logic busy;
  logic [31:0] rd;
  int error_cnt = 0;
  int comparisons = 0;
  // The clr_wr clear lands only on the edge that takes a write; clr_lvl clears on any edge
  assign compare_clear_i = clr_lvl | (clr_wr & avs_write_i & avs_waitrequest_o);
  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  stc_timer uut (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .instr_tick_i, .sleep_i, .compare_clear_i, .port_direction_bits_i, .ext_count_pin_i,
    .osc_input_pin_i, .osc_pin_input_only_o, .overflow_irq_o, .wake_o,
    .time_base_valid_o, .count_o);
  stc_clk_source src (.clk_sys_i, .go_i(go), .pulses_i(pulses), .use_osc_i(use_osc),
    .slow_i(slow), .ext_count_pin_o(ext_count_pin_i), .osc_input_pin_o(osc_input_pin_i),
    .busy_o(busy));
  // ****************
  // Tasks
  // ****************
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 20)
    begin
      error_cnt++;
      complete_run();
    end
  endtask : acc
  task automatic set_cnt(input logic [15:0] v);
    acc(1'b1, STC_OFS_COUNT_LOW, {24'h0, v[7:0]});
    acc(1'b1, STC_OFS_COUNT_HIGH, {24'h0, v[15:8]});
  endtask : set_cnt
  task automatic tick(input int n);
    repeat (n)
    begin
      instr_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      instr_tick_i <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask : tick
  task automatic burst(input logic [7:0] n, input logic o, input logic s);
    int k;
    k = 0;
    pulses <= n;
    use_osc <= o;
    slow <= s;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end while (busy === 1'b1 && k < 2000);
    repeat (2) @(posedge clk_sys_i);
    if (k >= 2000)
    begin
      error_cnt++;
      complete_run();
    end
  endtask : burst
  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    acc(1'b0, STC_OFS_CONTROL, 32'h0);
    check(rd, {26'h0, STC_CONTROL_RESET});
    acc(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    // A write without byte lane 0 must leave the control word alone
    avs_byteenable_i <= 4'he;
    acc(1'b1, STC_OFS_CONTROL, 32'h3f);
    avs_byteenable_i <= 4'hf;
    acc(1'b0, STC_OFS_CONTROL, 32'h0);
    check(rd, {26'h0, STC_CONTROL_RESET});
    $display("Reset test done");
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b1, STC_OFS_CONTROL, 32'h0);
      set_cnt(16'h0000);
      acc(1'b1, STC_OFS_CONTROL, 32'(p << 4) | 32'h5);
      tick(8);
      check(32'(count_o), 32'(16'h8 >> p));
    end
    tick(5);
    set_cnt(16'h0000);
    tick(11);
    check(32'(count_o), 32'h1);
    acc(1'b1, STC_OFS_CONTROL, 32'h0);
    tick(4);
    check(32'(count_o), 32'h1);
    $display("Prescale test done");
    set_cnt(16'hffff);
    acc(1'b1, STC_OFS_IRQ, 32'h1);
    acc(1'b1, STC_OFS_CONTROL, 32'h1);
    tick(1);
    check(32'(count_o), 32'h0);
    acc(1'b0, STC_OFS_IRQ, 32'h0);
    check(rd, 32'h1);
    check(32'(overflow_irq_o), 32'h0);
    acc(1'b1, STC_OFS_IRQ, 32'h2);
    check(32'(overflow_irq_o), 32'h1);
    acc(1'b1, STC_OFS_IRQ, 32'h3);
    check(32'(overflow_irq_o), 32'h0);
    $display("Overflow test done");
    acc(1'b1, STC_OFS_CONTROL, 32'h0);
    set_cnt(16'h1234);
    clr_wr <= 1'b1;
    acc(1'b1, STC_OFS_COUNT_LOW, 32'h5a);
    clr_wr <= 1'b0;
    check(32'(count_o), 32'h125a);
    acc(1'b0, STC_OFS_COUNT_HIGH, 32'h0);
    check(rd, 32'h12);
    acc(1'b0, STC_OFS_COUNT_LOW, 32'h0);
    check(rd, 32'h5a);
    clr_lvl <= 1'b1;
    @(posedge clk_sys_i);
    clr_lvl <= 1'b0;
    @(posedge clk_sys_i);
    check(32'(count_o), 32'h0);
    $display("Compare clear test done");
    acc(1'b1, STC_OFS_CONTROL, 32'h3);
    burst(8'h05, 1'b0, 1'b0);
    check(32'(count_o), 32'h5);
    check(32'(osc_pin_input_only_o), 32'h1);
    acc(1'b1, STC_OFS_CONTROL, 32'hb);
    check(32'(osc_pin_input_only_o), 32'h3);
    burst(8'h03, 1'b1, 1'b1);
    check(32'(count_o), 32'h8);
    $display("Counter test done");
    sleep_i <= 1'b1;
    burst(8'h04, 1'b1, 1'b0);
    check(32'(count_o), 32'h8);
    acc(1'b1, STC_OFS_CONTROL, 32'h0);
    set_cnt(16'hfffe);
    acc(1'b1, STC_OFS_IRQ, 32'h2);
    acc(1'b1, STC_OFS_CONTROL, 32'h7);
    check(32'(time_base_valid_o), 32'h0);
    burst(8'h02, 1'b0, 1'b0);
    check(32'(count_o), 32'h0);
    check(32'(wake_o), 32'h1);
    $display("Sleep test done");
    complete_run();
  end
endmodule : stc_timer_tb
`default_nettype wire
